// file: hdl/relay_point_pkg.sv
// Package with constants and types of the relay output point logic.
package relay_point_pkg;
  // Channel count and clock rate.
  localparam int NCH = 6;
  localparam int CLK_HZ = 50_000_000;
  // Exchange period with the controller, in milliseconds.
  localparam int CYCLE_TIME_MS = 1000;
  localparam int CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_TIME_MS;
  // Settling time of the override switch-board filter, in microseconds.
  localparam int FILT_TIME_US = 10000;
  localparam int FILT_CLKS = CLK_HZ / 1_000_000 * FILT_TIME_US;
  // Register byte offsets.
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_CFG = 8'h04;
  localparam logic [7:0] ADR_FEEDBACK = 8'h08;
  localparam logic [7:0] ADR_MAN_CNT = 8'h0C;
  localparam logic [7:0] ADR_FILT_CNT = 8'h10;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADR_POSITION = 8'h1C;
  // Field positions.
  localparam int CFG_SENSE_LSB = 8;
  localparam int FB_INV_LSB = 8;
  localparam int IRQ_CYCLE_BIT = 6;
  // Reset values and other fixed constants.
  localparam logic [5:0] CFG_EN_RST = 6'h3F;
  localparam logic [5:0] SENSE_RST = 6'h00;
  localparam logic [5:0] CH_RST = 6'h00;
  localparam logic [6:0] IRQ_RST = 7'h00;
  localparam logic [11:0] POS_RST = 12'h000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] TIMER_RST = 32'h0000_0000;
  localparam logic [31:0] TIMER_ONE = 32'h0000_0001;
  // Override switch positions, two bits per channel.
  typedef enum logic [1:0] {
    OVR_AUTO = 2'h0,
    OVR_OFF = 2'h1,
    OVR_ON = 2'h2
  } ovr_pos_t;
  // Filter states.
  typedef enum logic {
    FILT_IDLE = 1'h0,
    FILT_HOLD = 1'h1
  } filt_state_t;
  // Feedback of all channels: invalid flags and actuator values.
  typedef struct packed {
    logic [5:0] inv;
    logic [5:0] val;
  } feedback_t;
endpackage

// file: hdl/relay_output_point.sv
// Six-channel relay output point with manual override and counters.
//
// Operation
// - Six channels, each relay driven from its own status value.
// - Each channel LED is dark when status is off, lit when on.
// - Values are exchanged with the controller once per second.
// - Normally-open energises relay on status 1; normally-closed inverts.
// - In automatic or with no override module, feedback equals command.
// - Manual position sets status; feedback marked invalid, value is actual.
// - Feedback sent on command write in auto, on switch change in manual.
// - Sixteen-bit counter counts every filtered override switch position transition.
// - Sixteen-bit counter counts each override filter activation.
// - Config 0 stops channel updates; config 1, the default, is binary.
module relay_output_point #(
  parameter int CYCLE_CLKS_P = relay_point_pkg::CYCLE_CLKS,
  parameter int FILT_CLKS_P = relay_point_pkg::FILT_CLKS
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Override module.
  input wire logic override_fitted_i,
  input wire logic [11:0] override_board_i,
  // Relays, LEDs and feedback.
  output logic [5:0] relay_o,
  output logic [5:0] led_o,
  output relay_point_pkg::feedback_t feedback_o,
  output logic [5:0] feedback_send_o,
  output logic cycle_tick_o,
  output logic irq_o
);

  // Byte-lane merge of a write into an old register value.
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Number of set bits in a channel vector, sized for the counters.
  function automatic logic [15:0] ones(input logic [5:0] v);
    logic [15:0] n;
    n = relay_point_pkg::CNT_RST;
    for (int i = 0; i < relay_point_pkg::NCH; i++) begin
      n = n + {15'h0000, v[i]};
    end
    return n;
  endfunction

  // A position is manual when forced off or forced on.
  function automatic logic is_manual(input logic [1:0] p);
    return (p == relay_point_pkg::OVR_OFF) || (p == relay_point_pkg::OVR_ON);
  endfunction

  // Bus state.
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [5:0] cmd_r, cmd_nxt;
  logic [5:0] cfg_en_r, cfg_en_nxt;
  logic [5:0] sense_r, sense_nxt;
  logic [6:0] irq_mask_r, irq_mask_nxt;
  logic wr, cmd_wr;
  logic [31:0] cfg_w;
  // Filter state.
  relay_point_pkg::filt_state_t filt_st_r, filt_st_nxt;
  logic [31:0] filt_cnt_r, filt_cnt_nxt;
  logic [11:0] board_r, board_nxt;
  logic [15:0] filt_act_r, filt_act_nxt;
  // Channel state.
  logic [11:0] pos_r, pos_nxt;
  logic [5:0] status_r, status_nxt;
  logic [5:0] relay_r, relay_nxt;
  logic [5:0] man_r, man_nxt;
  logic [5:0] send_r, send_nxt;
  logic [5:0] changed;
  logic [15:0] man_cnt_r, man_cnt_nxt;
  // Exchange timer and interrupts.
  logic [31:0] cyc_cnt_r, cyc_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [6:0] irq_stat_r, irq_stat_nxt;
  logic irq_r, irq_nxt;

  // Bus decode. A write lands at the edge where the master sees ack, so
  // the register changes exactly when the master considers it done.
  always_comb begin
    ack_nxt = cyc_i & stb_i & ~ack_r;
    wr = cyc_i & stb_i & we_i & ack_r;
    cmd_wr = wr && (adr_i == relay_point_pkg::ADR_CMD) && sel_i[0];
    cmd_nxt = cmd_r;
    cfg_en_nxt = cfg_en_r;
    sense_nxt = sense_r;
    irq_mask_nxt = irq_mask_r;
    cfg_w = wmerge({18'h00000, sense_r, 2'h0, cfg_en_r}, dat_i, sel_i);
    if (cmd_wr) begin
      cmd_nxt = dat_i[5:0];
    end
    if (wr && adr_i == relay_point_pkg::ADR_CFG) begin
      cfg_en_nxt = cfg_w[5:0];
      sense_nxt = cfg_w[relay_point_pkg::CFG_SENSE_LSB +: 6];
    end
    if (wr && adr_i == relay_point_pkg::ADR_IRQ_MASK && sel_i[0]) begin
      irq_mask_nxt = dat_i[6:0];
    end
    dat_nxt = relay_point_pkg::WORD_ZERO;
    if (ack_nxt && !we_i) begin
      case (adr_i)
        relay_point_pkg::ADR_CMD: dat_nxt = {26'h0000000, cmd_r};
        relay_point_pkg::ADR_CFG:
          dat_nxt = {18'h00000, sense_r, 2'h0, cfg_en_r};
        relay_point_pkg::ADR_FEEDBACK: begin
          // Invalid flags sit in the second byte (bits 13:8), in line with the sense field.
          dat_nxt[relay_point_pkg::FB_INV_LSB +: 6] = feedback_o.inv;
          dat_nxt[5:0] = feedback_o.val;
        end
        relay_point_pkg::ADR_MAN_CNT: dat_nxt = {16'h0000, man_cnt_r};
        relay_point_pkg::ADR_FILT_CNT: dat_nxt = {16'h0000, filt_act_r};
        relay_point_pkg::ADR_IRQ_STAT: dat_nxt = {25'h0000000, irq_stat_r};
        relay_point_pkg::ADR_IRQ_MASK: dat_nxt = {25'h0000000, irq_mask_r};
        relay_point_pkg::ADR_POSITION: dat_nxt = {20'h00000, pos_r};
        default: dat_nxt = relay_point_pkg::WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= relay_point_pkg::WORD_ZERO;
      cmd_r <= relay_point_pkg::CH_RST;
      cfg_en_r <= relay_point_pkg::CFG_EN_RST;
      sense_r <= relay_point_pkg::SENSE_RST;
      irq_mask_r <= relay_point_pkg::IRQ_RST;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      cmd_r <= cmd_nxt;
      cfg_en_r <= cfg_en_nxt;
      sense_r <= sense_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Switch-board filter. A difference between the raw board and the
  // accepted board starts a hold; the raw board is taken once it has
  // differed from it for the settling time, which hides contact bounce.
  always_comb begin
    filt_st_nxt = filt_st_r;
    filt_cnt_nxt = filt_cnt_r;
    board_nxt = board_r;
    filt_act_nxt = filt_act_r;
    case (filt_st_r)
      relay_point_pkg::FILT_IDLE: begin
        if (override_board_i != board_r) begin
          filt_st_nxt = relay_point_pkg::FILT_HOLD;
          filt_cnt_nxt = relay_point_pkg::TIMER_ONE;
          filt_act_nxt = filt_act_r + 16'h0001;
        end
      end
      relay_point_pkg::FILT_HOLD: begin
        if (override_board_i == board_r) begin
          filt_st_nxt = relay_point_pkg::FILT_IDLE;
        end else if (filt_cnt_r >= 32'(FILT_CLKS_P)) begin
          board_nxt = override_board_i;
          filt_st_nxt = relay_point_pkg::FILT_IDLE;
        end else begin
          filt_cnt_nxt = filt_cnt_r + relay_point_pkg::TIMER_ONE;
        end
      end
      default: filt_st_nxt = relay_point_pkg::FILT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_st_r <= relay_point_pkg::FILT_IDLE;
      filt_cnt_r <= relay_point_pkg::TIMER_RST;
      board_r <= relay_point_pkg::POS_RST;
      filt_act_r <= relay_point_pkg::CNT_RST;
    end else begin
      filt_st_r <= filt_st_nxt;
      filt_cnt_r <= filt_cnt_nxt;
      board_r <= board_nxt;
      filt_act_r <= filt_act_nxt;
    end
  end

  // One-second exchange timer.
  always_comb begin
    tick_nxt = (cyc_cnt_r == 32'(CYCLE_CLKS_P - 1));
    cyc_cnt_nxt = tick_nxt ? relay_point_pkg::TIMER_RST
                           : cyc_cnt_r + relay_point_pkg::TIMER_ONE;
  end

  // Channels. A missing override module reads as automatic everywhere.
  always_comb begin
    pos_nxt = override_fitted_i ? board_r : relay_point_pkg::POS_RST;
    status_nxt = status_r;
    relay_nxt = relay_r;
    man_nxt = man_r;
    send_nxt = relay_point_pkg::CH_RST;
    for (int c = 0; c < relay_point_pkg::NCH; c++) begin
      changed[c] = pos_nxt[2*c +: 2] != pos_r[2*c +: 2];
      if (cfg_en_r[c]) begin
        if (is_manual(pos_nxt[2*c +: 2])) begin
          status_nxt[c] = pos_nxt[2*c +: 2] == relay_point_pkg::OVR_ON;
          man_nxt[c] = 1'b1;
          send_nxt[c] = changed[c] | tick_nxt;
        end else begin
          status_nxt[c] = cmd_nxt[c];
          man_nxt[c] = 1'b0;
          send_nxt[c] = cmd_wr | changed[c] | tick_nxt;
        end
        relay_nxt[c] = status_nxt[c] ^ sense_nxt[c];
      end
    end
    man_cnt_nxt = man_cnt_r + ones(changed);
  end

  // Status bits are sticky; a new event wins over a clear written to it.
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr && adr_i == relay_point_pkg::ADR_IRQ_STAT && sel_i[0]) begin
      irq_stat_nxt = irq_stat_r & ~dat_i[6:0];
    end
    irq_stat_nxt = irq_stat_nxt | {tick_nxt, send_nxt};
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_r <= relay_point_pkg::POS_RST;
      status_r <= relay_point_pkg::CH_RST;
      relay_r <= relay_point_pkg::SENSE_RST;
      man_r <= relay_point_pkg::CH_RST;
      send_r <= relay_point_pkg::CH_RST;
      man_cnt_r <= relay_point_pkg::CNT_RST;
      cyc_cnt_r <= relay_point_pkg::TIMER_RST;
      tick_r <= 1'b0;
      irq_stat_r <= relay_point_pkg::IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      pos_r <= pos_nxt;
      status_r <= status_nxt;
      relay_r <= relay_nxt;
      man_r <= man_nxt;
      send_r <= send_nxt;
      man_cnt_r <= man_cnt_nxt;
      cyc_cnt_r <= cyc_cnt_nxt;
      tick_r <= tick_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Outputs come straight from flip-flops; the LED mirrors the status.
  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign relay_o = relay_r;
  assign led_o = status_r;
  assign feedback_o = '{inv: man_r, val: status_r};
  assign feedback_send_o = send_r;
  assign cycle_tick_o = tick_r;
  assign irq_o = irq_r;

  // Checks on the channel, counter, timer and bus behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cmd_write_auto;
    cmd_wr && cfg_en_r[0] && !is_manual(pos_nxt[1:0]);
  endsequence

  sequence s_forced_on;
    override_fitted_i && cfg_en_r[1] &&
      board_r[3:2] == relay_point_pkg::OVR_ON [*2];
  endsequence

  // A disabled channel keeps its old relay even if its sense is rewritten,
  // so only channels that were processed at the last edge are checked.
  chk_relay_sense: assert property (
    ((relay_o ^ led_o ^ sense_r) & $past(cfg_en_r)) == 6'h00)
    else $error("relay does not match status and sense");
  chk_led_status: assert property (($past(cfg_en_r[0]) &&
    !feedback_o.inv[0]) |-> led_o[0] == cmd_r[0])
    else $error("LED differs from commanded status");
  chk_auto_follow: assert property (s_cmd_write_auto |=>
    feedback_o.val[0] == $past(dat_i[0]) && !feedback_o.inv[0])
    else $error("auto feedback does not follow command");
  chk_manual_inv: assert property (s_forced_on |->
    feedback_o.inv[1] && feedback_o.val[1])
    else $error("manual feedback not marked invalid");
  chk_send_auto: assert property (s_cmd_write_auto |=>
    feedback_send_o[0])
    else $error("no feedback sent after command write");
  chk_man_count: assert property ($changed(man_cnt_r) |->
    $changed(pos_r))
    else $error("manual count moved without a transition");
  chk_filt_count: assert property ((filt_st_r == 1'b0 &&
    override_board_i != board_r) |=> filt_act_r == $past(filt_act_r) + 16'h1)
    else $error("filter activation not counted");
  chk_disabled_hold: assert property (!cfg_en_r[0] [*2] |->
    $stable(relay_o[0]))
    else $error("disabled channel changed its relay");
  chk_count_wrap: assert property (($past(man_cnt_r) == 16'hFFFF &&
    $changed(man_cnt_r)) |-> man_cnt_r < 16'h0006)
    else $error("manual count did not wrap");
  chk_cycle_gap: assert property (cycle_tick_o |=>
    !cycle_tick_o [*3])
    else $error("exchange ticks too close");
  chk_bus_ack: assert property ((cyc_i && stb_i && !ack_o) |=>
    ack_o ##1 !ack_o)
    else $error("ack not a single cycle pulse");

endmodule // relay_output_point

// file: testbench/net_controller_model.sv
// Remote controller model: a Wishbone master that issues channel commands.
module net_controller_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Slave answer.
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // Master request.
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus starts idle at time zero.
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // One classic cycle; the request is held until ack is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    // No request is started while the slave is still held in reset.
    do @(posedge clk_i); while (rst_i === 1'b1);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= wd;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released address and data lines show the inverse so a stale value is never trusted.
    adr_o <= ~a;
    dat_o <= ~wd;
  endtask
endmodule // net_controller_model

// file: testbench/relay_output_point_test.sv
// Self-checking testbench of the relay output point.
module relay_output_point_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 1000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fitted = 1'b0;
  logic [11:0] board = 12'h000;
  logic cyc, stb, we, ack, tick, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [5:0] relay, led, send;
  relay_point_pkg::feedback_t fb;
  int errors = 0;
  int total_checks = 0;
  int n;

  // A 50 MHz clock.
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  net_controller_model net_controller_model_i (.clk_i(clk_i),
    .rst_i(rst_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // The cycle is shortened so that two ticks fit in the run.
  relay_output_point #(.CYCLE_CLKS_P(CYC), .FILT_CLKS_P(4))
      relay_output_point_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .override_fitted_i(fitted),
    .override_board_i(board), .relay_o(relay), .led_o(led),
    .feedback_o(fb), .feedback_send_o(send), .cycle_tick_o(tick),
    .irq_o(irq));

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    net_controller_model_i.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    net_controller_model_i.xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask

  // Moves the override board and waits past the filter hold.
  task automatic set_board(input logic [11:0] b);
    @(posedge clk_i);
    board <= b;
    repeat (12) @(posedge clk_i);
    #1;
  endtask

  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    complete_run();
  end

  // Main test sequence.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(relay_point_pkg::ADR_CFG, 32'h0000_003F);
    rd(relay_point_pkg::ADR_MAN_CNT, 32'h0000_0000);
    rd(relay_point_pkg::ADR_FILT_CNT, 32'h0000_0000);
    wr(relay_point_pkg::ADR_CMD, 32'h0000_002D);
    #1;
    chk(32'(send), 32'h0000_003F);
    chk(32'(led), 32'h0000_002D);
    chk(32'(relay), 32'h0000_002D);
    chk(32'(fb), 32'h0000_002D);
    rd(relay_point_pkg::ADR_FEEDBACK, 32'h0000_002D);
    wr(relay_point_pkg::ADR_CFG, 32'h0000_143F);
    #1;
    chk(32'(relay), 32'h0000_0039);
    chk(32'(led), 32'h0000_002D);
    // Channel 0 is disabled, so it must keep its old state and stay quiet.
    wr(relay_point_pkg::ADR_CFG, 32'h0000_003E);
    wr(relay_point_pkg::ADR_CMD, 32'h0000_0000);
    #1;
    chk(32'(send), 32'h0000_003E);
    chk(32'(led), 32'h0000_0001);
    wr(relay_point_pkg::ADR_CFG, 32'h0000_003F);
    @(posedge clk_i);
    fitted <= 1'b1;
    set_board(12'h018);
    chk(32'(led), 32'h0000_0002);
    chk(32'(fb), 32'h0000_0182);
    rd(relay_point_pkg::ADR_FEEDBACK, 32'h0000_0602);
    rd(relay_point_pkg::ADR_MAN_CNT, 32'h0000_0002);
    rd(relay_point_pkg::ADR_FILT_CNT, 32'h0000_0001);
    rd(relay_point_pkg::ADR_POSITION, 32'h0000_0018);
    wr(relay_point_pkg::ADR_CMD, 32'h0000_003F);
    #1;
    chk(32'(led), 32'h0000_003B);
    // A glitch shorter than the hold is counted but never accepted.
    @(posedge clk_i);
    board <= 12'h000;
    repeat (2) @(posedge clk_i);
    set_board(12'h018);
    rd(relay_point_pkg::ADR_FILT_CNT, 32'h0000_0002);
    rd(relay_point_pkg::ADR_MAN_CNT, 32'h0000_0002);
    set_board(12'h000);
    rd(relay_point_pkg::ADR_MAN_CNT, 32'h0000_0004);
    chk(32'(fb), 32'h0000_003F);
    // Interrupt is masked, then unmasked, then cleared.
    wr(relay_point_pkg::ADR_IRQ_MASK, 32'h0000_0000);
    wr(relay_point_pkg::ADR_CMD, 32'h0000_003F);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0000);
    wr(relay_point_pkg::ADR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0001);
    rd(relay_point_pkg::ADR_IRQ_STAT, 32'h0000_003F);
    wr(relay_point_pkg::ADR_IRQ_STAT, 32'h0000_007F);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0000);
    rd(relay_point_pkg::ADR_IRQ_STAT, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    // The exchange tick repeats once per cycle period.
    do @(posedge clk_i); while (tick !== 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1);
    chk(32'(n), 32'(CYC));
    complete_run();
  end
endmodule // relay_output_point_test
